// >>> rtl/addr_gen_cfg.svh
// constants for operand and branch-target address generation
`ifndef ADDR_GEN_CFG_SVH
`define ADDR_GEN_CFG_SVH
`define SFR_BASE 8'h80
`define BIT_RAM_BASE 8'h20
`define WREG_BANK_MASK 8'h18
`define BIT_SFR_LOW_MASK 3'h0
`define RST_FLAG 1'b0
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_INDEX 3'h0
`endif

// >>> rtl/addr_gen_pkg.sv
// types for operand and branch-target address generation
package addr_gen_pkg;
  typedef enum logic [3:0]
  {
    mode_none,
    mode_register,
    mode_direct,
    mode_reg_indirect,
    mode_immediate,
    mode_data_pointer_load,
    mode_ext_read,
    mode_ext_write,
    mode_ext_indirect,
    mode_code_pc,
    mode_code_data_pointer,
    mode_relative,
    mode_page,
    mode_far,
    mode_bit
  } addr_mode_t;
  typedef enum logic [1:0]
  {
    space_none,
    space_ram,
    space_sfr,
    space_upper_ram
  } space_t;
endpackage

// >>> rtl/bit_address_map.sv
// maps a bit address onto a byte location and bit index
`timescale 1ns/100ps
`include "addr_gen_cfg.svh"
module bit_address_map
  import addr_gen_pkg::*;
(
  input wire logic [7:0] bit_addr, // bit address from instruction
  output logic [7:0] byte_addr, // containing byte
  output logic [2:0] bit_index, // bit within byte
  output addr_gen_pkg::space_t byte_space // ram or sfr
);
  // low half: ram bytes 20h-2Fh, bit 00h is byte 20h bit 0
  wire is_sfr_bit = bit_addr[7];
  wire [7:0] ram_byte = `BIT_RAM_BASE + {4'h0, bit_addr[6:3]}; // RQ15 RQ13
  // upper half: sfr base ends in 0h or 8h, eight consecutive bit addresses
  wire [7:0] sfr_byte = {bit_addr[7:3], `BIT_SFR_LOW_MASK}; // RQ14 RQ13
  assign byte_addr = is_sfr_bit ? sfr_byte : ram_byte;
  assign bit_index = bit_addr[2:0];
  assign byte_space = is_sfr_bit ? space_sfr : space_ram;
endmodule

// >>> rtl/operand_address_generation.sv
// operand location and branch target generation for the core
`timescale 1ns/100ps
`include "addr_gen_cfg.svh"
// Summary of operation
// [RQ1] register mode picks one of eight working registers from opcode low bits
// [RQ2] direct mode uses byte two; below 80h is ram, 80h and above sfr
// [RQ3] register-indirect uses R0 or R1 contents; upper addresses reach upper ram
// [RQ4] register-indirect never reaches special function registers
// [RQ5] immediate mode takes byte two as constant for first-byte destination
// [RQ6] data pointer immediate load takes the two bytes after the opcode
// [RQ7] external moves use the 16-bit data pointer, read or write accumulator
// [RQ8] external indirect with 8-bit register address is unsupported
// [RQ9] code constant read adds accumulator to pc or data pointer
// [RQ10] relative jump adds signed byte two to program counter
// [RQ11] page jump and call join next-address top 5 bits with 11-bit field
// [RQ12] far jump and call use the two bytes after the opcode
// [RQ13] bit mode changes one bit; ram 20h-2Fh and sfr ending 0h or 8h
// [RQ14] bit-addressable sfr bits sit at base through base plus seven
// [RQ15] bit addresses 00h-7Fh map onto ram bytes 20h-2Fh, lowest first
module operand_address_generation
  import addr_gen_pkg::*;
(
  input wire logic clk, // 20 MHz core clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic decode_valid, // instruction bytes valid this cycle
  input wire addr_gen_pkg::addr_mode_t mode, // addressing mode of instruction
  input wire logic [7:0] opcode, // first instruction byte
  input wire logic [7:0] byte2, // second instruction byte
  input wire logic [7:0] byte3, // third instruction byte
  input wire logic [7:0] reg_r0, // working register 0 contents
  input wire logic [7:0] reg_r1, // working register 1 contents
  input wire logic [1:0] bank_sel, // working register bank
  input wire logic [7:0] accumulator, // accumulator contents
  input wire logic [15:0] data_pointer, // data pointer contents
  input wire logic [15:0] pc_next, // address of next instruction
  input wire logic [7:0] bit_byte_value, // current byte holding the target bit
  input wire logic bit_value, // value to write in bit mode
  output logic op_valid, // op_space and op_addr hold an operand location
  output space_t op_space, // internal space of operand
  output logic [7:0] op_addr, // internal operand address
  output logic [7:0] op_imm, // immediate constant
  output logic imm_valid, // immediate constant present
  output logic [15:0] data_pointer_load_value, // value for data pointer load
  output logic data_pointer_load, // load data pointer
  output logic [15:0] ext_addr, // external data space address
  output logic ext_read, // external data move into accumulator
  output logic ext_write, // external data move from accumulator
  output logic [15:0] code_addr, // program memory address of constant
  output logic code_read, // constant fetch into accumulator
  output logic [15:0] jump_target, // branch destination
  output logic jump_valid, // branch target valid
  output logic [2:0] bit_index, // bit within byte for bit mode
  output logic [7:0] bit_write_byte, // byte with only the target bit changed
  output logic bit_valid, // bit mode result valid
  output logic unsupported // unsupported addressing mode seen
);
  // decode of the mode into strobes
  wire is_reg = decode_valid && (mode == mode_register);
  wire is_dir = decode_valid && (mode == mode_direct);
  wire is_ind = decode_valid && (mode == mode_reg_indirect);
  wire is_imm = decode_valid && (mode == mode_immediate);
  wire is_dpl = decode_valid && (mode == mode_data_pointer_load);
  wire is_xrd = decode_valid && (mode == mode_ext_read);
  wire is_xwr = decode_valid && (mode == mode_ext_write);
  wire is_xind = decode_valid && (mode == mode_ext_indirect);
  wire is_cpc = decode_valid && (mode == mode_code_pc);
  wire is_cdp = decode_valid && (mode == mode_code_data_pointer);
  wire is_rel = decode_valid && (mode == mode_relative);
  wire is_page = decode_valid && (mode == mode_page);
  wire is_far = decode_valid && (mode == mode_far);
  wire is_bit = decode_valid && (mode == mode_bit);

  // space of a direct address: low half ram, upper half sfr
  function automatic space_t direct_space(input logic [7:0] a);
    direct_space = (a >= `SFR_BASE) ? space_sfr : space_ram;
  endfunction

  // working register address in the selected bank
  wire [7:0] reg_addr = {3'h0, bank_sel, opcode[2:0]}; // RQ1
  // indirect pointer register chosen by opcode bit 0
  wire [7:0] ind_addr = opcode[0] ? reg_r1 : reg_r0; // RQ3
  // upper indirect addresses go to upper ram, never to sfr
  wire [1:0] ind_space_raw = (ind_addr >= `SFR_BASE) ? space_upper_ram : space_ram; // RQ4 RQ3
  wire space_t ind_space = space_t'(ind_space_raw);
  wire space_t dir_space = direct_space(byte2); // RQ2

  // bit address mapping
  wire [7:0] bmap_byte;
  wire [2:0] bmap_index;
  space_t bmap_space;
  bit_address_map u_bit_map
  (
    .bit_addr(byte2),
    .byte_addr(bmap_byte),
    .bit_index(bmap_index),
    .byte_space(bmap_space)
  );
  // read-modify-write: only the addressed bit changes, the other seven keep their value
  wire [7:0] bit_new;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_bit_merge
      assign bit_new[gi] = (bmap_index == 3'(gi)) ? bit_value : bit_byte_value[gi]; // RQ13
    end
  endgenerate

  // code constant address: accumulator plus pc or data pointer
  wire [15:0] code_base = is_cpc ? pc_next : data_pointer;
  wire [15:0] code_sum = code_base + {8'h00, accumulator}; // RQ9

  // branch targets
  wire [15:0] rel_target = pc_next + {{8{byte2[7]}}, byte2}; // RQ10
  wire [15:0] page_target = {pc_next[15:11], opcode[7:5], byte2}; // RQ11
  wire [15:0] far_target = {byte2, byte3}; // RQ12
  wire [15:0] sel_target = is_rel ? rel_target : (is_page ? page_target : far_target);

  // operand address and space selection
  wire [7:0] next_op_addr = is_reg ? reg_addr : (is_ind ? ind_addr : (is_bit ? bmap_byte : byte2));
  wire space_t next_op_space = is_reg ? space_ram :
                               is_ind ? ind_space :
                               is_bit ? bmap_space :
                               is_dir ? dir_space : space_none;
  wire next_op_valid = is_reg || is_dir || is_ind || is_bit;

  // strobes of the other result groups, code_read shared by two modes and jump_valid by three
  wire next_imm_valid = is_imm; // RQ5
  wire next_data_pointer_load = is_dpl; // RQ6
  wire next_ext_read = is_xrd; // RQ7
  wire next_ext_write = is_xwr; // RQ7
  wire next_unsupported = is_xind; // RQ8
  wire next_code_read = is_cpc || is_cdp; // RQ9
  wire next_jump_valid = is_rel || is_page || is_far; // RQ10 RQ11 RQ12
  wire next_bit_valid = is_bit; // RQ13

  // words that only pass through a register
  wire [15:0] next_data_pointer_load_value = {byte2, byte3}; // RQ6
  wire [15:0] next_ext_addr = data_pointer; // RQ7

  // operand location strobe
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      op_valid <= `RST_FLAG;
    end
    else
    begin
      op_valid <= next_op_valid; // RQ1 RQ2 RQ3
    end
  end

  // operand location and its space
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      op_space <= space_none;
      op_addr <= `RST_BYTE;
    end
    else
    begin
      op_space <= next_op_space; // RQ4
      op_addr <= next_op_addr;
    end
  end

  // immediate constant
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      imm_valid <= `RST_FLAG;
      op_imm <= `RST_BYTE;
    end
    else
    begin
      imm_valid <= next_imm_valid; // RQ5
      op_imm <= byte2;
    end
  end

  // data pointer load
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      data_pointer_load <= `RST_FLAG;
      data_pointer_load_value <= `RST_WORD;
    end
    else
    begin
      data_pointer_load <= next_data_pointer_load; // RQ6
      data_pointer_load_value <= next_data_pointer_load_value;
    end
  end

  // external data space strobes, data pointer addressing only
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ext_read <= `RST_FLAG;
      ext_write <= `RST_FLAG;
    end
    else
    begin
      ext_read <= next_ext_read; // RQ7
      ext_write <= next_ext_write; // RQ7
    end
  end

  // external data space address
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ext_addr <= `RST_WORD;
    end
    else
    begin
      ext_addr <= next_ext_addr;
    end
  end

  // refusal of external indirect, no external strobe is raised for it
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      unsupported <= `RST_FLAG;
    end
    else
    begin
      unsupported <= next_unsupported; // RQ8
    end
  end

  // code constant fetch address
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      code_read <= `RST_FLAG;
      code_addr <= `RST_WORD;
    end
    else
    begin
      code_read <= next_code_read; // RQ9
      code_addr <= code_sum;
    end
  end

  // branch strobe, target formed without any extra fetch
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      jump_valid <= `RST_FLAG;
    end
    else
    begin
      jump_valid <= next_jump_valid; // RQ10 RQ11 RQ12
    end
  end

  // branch target
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      jump_target <= `RST_WORD;
    end
    else
    begin
      jump_target <= sel_target;
    end
  end

  // bit mode strobe
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bit_valid <= `RST_FLAG;
    end
    else
    begin
      bit_valid <= next_bit_valid; // RQ13
    end
  end

  // bit mode result
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bit_index <= `RST_INDEX;
      bit_write_byte <= `RST_BYTE;
    end
    else
    begin
      bit_index <= bmap_index; // RQ14
      bit_write_byte <= bit_new;
    end
  end
endmodule

// >>> verification/ram_model.sv
// internal ram model feeding working registers and bit bytes
`timescale 1ns/100ps
module ram_model
(
  input wire logic [1:0] bank_sel, // register bank
  input wire logic [7:0] rd_addr, // byte read address
  output logic [7:0] reg_r0, // bank register 0
  output logic [7:0] reg_r1, // bank register 1
  output logic [7:0] rd_data // byte at rd_addr
);
  // contents are a fixed function of the address
  assign reg_r0 = ~{3'h0, bank_sel, 3'h0};
  assign reg_r1 = ~{3'h0, bank_sel, 3'h1};
  assign rd_data = rd_addr ^ 8'h5A;
endmodule

// >>> verification/oag_chk.sv
// assertion checker for operand address generation
`timescale 1ns/100ps
module oag_chk
  import addr_gen_pkg::*;
(
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic decode_valid, // request
  input wire addr_mode_t mode, // mode
  input wire logic [7:0] opcode, // byte one
  input wire logic [7:0] byte2, // byte two
  input wire logic [1:0] bank_sel, // bank
  input wire logic [7:0] reg_r0, // r0
  input wire logic [7:0] reg_r1, // r1
  input wire logic [15:0] pc_next, // next pc
  input wire logic [15:0] data_pointer, // pointer
  input wire logic [7:0] bit_byte_value, // old byte
  input wire logic bit_value, // new bit
  input wire space_t op_space, // space
  input wire logic [7:0] op_addr, // address
  input wire logic ext_read, // ext read
  input wire logic ext_write, // ext write
  input wire logic [15:0] ext_addr, // ext address
  input wire logic unsupported, // refused
  input wire logic jump_valid, // jump
  input wire logic [15:0] jump_target, // target
  input wire logic [2:0] bit_index, // bit index
  input wire logic [7:0] bit_write_byte // new byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  addr_mode_t pm;
  // mode of the request answered this cycle
  always_ff @(posedge clk)
  begin
    pm <= decode_valid ? mode : mode_none;
  end
  property p_reg;
    pm == mode_register |-> op_space == space_ram && op_addr == {3'h0, $past(bank_sel), $past(opcode[2:0])};
  endproperty
  a_reg: assert property (p_reg) else $error("register address wrong");
  property p_dir;
    pm == mode_direct |-> op_addr == $past(byte2) && op_space == ($past(byte2[7]) ? space_sfr : space_ram);
  endproperty
  a_dir: assert property (p_dir) else $error("direct address wrong");
  property p_ind;
    pm == mode_reg_indirect |-> op_space != space_sfr && op_addr == ($past(opcode[0]) ? $past(reg_r1) : $past(reg_r0));
  endproperty
  a_ind: assert property (p_ind) else $error("indirect address wrong");
  property p_ext;
    (ext_read || ext_write) |-> ext_addr == $past(data_pointer) && !(ext_read && ext_write);
  endproperty
  a_ext: assert property (p_ext) else $error("external address wrong");
  property p_uns;
    decode_valid && mode == mode_ext_indirect |=> unsupported && !ext_read && !ext_write;
  endproperty
  a_uns: assert property (p_uns) else $error("external indirect not refused");
  property p_rel;
    decode_valid && mode == mode_relative |=> jump_valid && jump_target == $past(pc_next) + {{8{$past(byte2[7])}}, $past(byte2)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_page;
    pm == mode_page |-> jump_target == {$past(pc_next[15:11]), $past(opcode[7:5]), $past(byte2)};
  endproperty
  a_page: assert property (p_page) else $error("page target wrong");
  property p_bit;
    pm == mode_bit |-> bit_index == $past(byte2[2:0]) && bit_write_byte[bit_index] == $past(bit_value)
      && ((bit_write_byte ^ $past(bit_byte_value)) & ~(8'h01 << bit_index)) == 8'h00;
  endproperty
  a_bit: assert property (p_bit) else $error("bit write wrong");
  property p_idle;
    !decode_valid |=> !jump_valid && !ext_read && !ext_write;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe without request");
  c_bit: cover property (pm == mode_bit);
  c_uns: cover property (pm == mode_ext_indirect);
  c_jmp: cover property (pm == mode_far);
endmodule
bind operand_address_generation oag_chk u_chk (.clk, .nrst, .decode_valid, .mode, .opcode, .byte2, .bank_sel,
  .reg_r0, .reg_r1, .pc_next, .data_pointer, .bit_byte_value, .bit_value, .op_space, .op_addr, .ext_read,
  .ext_write, .ext_addr, .unsupported, .jump_valid, .jump_target, .bit_index, .bit_write_byte);

// >>> verification/testbench.sv
// self-checking testbench for operand address generation
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import addr_gen_pkg::*;
  logic clk, nrst, decode_valid, bit_value, op_valid, imm_valid, data_pointer_load, ext_read, ext_write;
  logic code_read, jump_valid, bit_valid, unsupported;
  addr_mode_t mode;
  space_t op_space;
  logic [1:0] bank_sel;
  logic [2:0] bit_index;
  logic [7:0] opcode, byte2, byte3, reg_r0, reg_r1, accumulator, bit_byte_value, op_addr, op_imm;
  logic [7:0] bit_write_byte, ram_addr;
  logic [15:0] data_pointer, pc_next, data_pointer_load_value, ext_addr, code_addr, jump_target;
  int err_total, total_checks;
  operand_address_generation DUT
  (
    .clk(clk),
    .nrst(nrst),
    .decode_valid(decode_valid),
    .mode(mode),
    .opcode(opcode),
    .byte2(byte2),
    .byte3(byte3),
    .reg_r0(reg_r0),
    .reg_r1(reg_r1),
    .bank_sel(bank_sel),
    .accumulator(accumulator),
    .data_pointer(data_pointer),
    .pc_next(pc_next),
    .bit_byte_value(bit_byte_value),
    .bit_value(bit_value),
    .op_valid(op_valid),
    .op_space(op_space),
    .op_addr(op_addr),
    .op_imm(op_imm),
    .imm_valid(imm_valid),
    .data_pointer_load_value(data_pointer_load_value),
    .data_pointer_load(data_pointer_load),
    .ext_addr(ext_addr),
    .ext_read(ext_read),
    .ext_write(ext_write),
    .code_addr(code_addr),
    .code_read(code_read),
    .jump_target(jump_target),
    .jump_valid(jump_valid),
    .bit_index(bit_index),
    .bit_write_byte(bit_write_byte),
    .bit_valid(bit_valid),
    .unsupported(unsupported)
  );
  ram_model u_ram (.bank_sel, .rd_addr(ram_addr), .reg_r0, .reg_r1, .rd_data(bit_byte_value));
  // one request cycle, outputs settled on return
  task automatic issue(addr_mode_t m, logic [7:0] op, logic [7:0] b2, logic [7:0] b3);
    @(negedge clk);
    decode_valid = 1'b1;
    mode = m;
    opcode = op;
    byte2 = b2;
    byte3 = b3;
    @(negedge clk);
    decode_valid = 1'b0;
  endtask
  task automatic t_operand;
    bank_sel = 2'h2;
    issue(mode_register, 8'hEF, 8'h00, 8'h00);
    `CHK({op_valid, op_space, op_addr}, {1'b1, space_ram, 8'h17})
    issue(mode_direct, 8'hE5, 8'h7F, 8'h00);
    `CHK({op_space, op_addr}, {space_ram, 8'h7F})
    issue(mode_direct, 8'hE5, 8'h80, 8'h00);
    `CHK({op_space, op_addr}, {space_sfr, 8'h80})
    issue(mode_reg_indirect, 8'hE7, 8'h00, 8'h00);
    `CHK({op_space, op_addr}, {space_upper_ram, 8'hEE})
  endtask
  task automatic t_immediate;
    issue(mode_immediate, 8'h74, 8'h40, 8'h00);
    `CHK({imm_valid, op_imm}, {1'b1, 8'h40})
    issue(mode_data_pointer_load, 8'h90, 8'h12, 8'h34);
    `CHK({data_pointer_load, data_pointer_load_value}, {1'b1, 16'h1234})
  endtask
  task automatic t_external;
    data_pointer = 16'hBEEF;
    issue(mode_ext_read, 8'hE0, 8'h00, 8'h00);
    `CHK({ext_read, ext_write, ext_addr}, {2'h2, 16'hBEEF})
    issue(mode_ext_write, 8'hF0, 8'h00, 8'h00);
    `CHK({ext_read, ext_write, ext_addr}, {2'h1, 16'hBEEF})
    issue(mode_ext_indirect, 8'hF2, 8'h00, 8'h00);
    `CHK({unsupported, ext_read, ext_write}, 3'h4)
    accumulator = 8'hF0;
    pc_next = 16'h10FF;
    issue(mode_code_pc, 8'h83, 8'h00, 8'h00);
    `CHK({code_read, code_addr}, {1'b1, 16'h11EF})
    issue(mode_code_data_pointer, 8'h93, 8'h00, 8'h00);
    `CHK(code_addr, 16'hBFDF)
  endtask
  task automatic t_branch;
    pc_next = 16'h1002;
    issue(mode_relative, 8'h80, 8'h34, 8'h00);
    `CHK({jump_valid, jump_target}, {1'b1, 16'h1036})
    issue(mode_relative, 8'h80, 8'h81, 8'h00);
    `CHK(jump_target, 16'h0F83)
    pc_next = 16'h4000;
    issue(mode_page, 8'hE1, 8'h00, 8'h00);
    `CHK(jump_target, 16'h4700)
    issue(mode_far, 8'h02, 8'h05, 8'h00);
    `CHK(jump_target, 16'h0500)
  endtask
  // one bit access against the ram model contents
  task automatic bit_case(logic [7:0] b2, logic [7:0] ba, space_t sp, logic v, logic [7:0] wb);
    ram_addr = ba;
    bit_value = v;
    issue(mode_bit, 8'hD2, b2, 8'h00);
    `CHK({bit_valid, op_space, op_addr}, {1'b1, sp, ba})
    `CHK({bit_index, bit_write_byte}, {b2[2:0], wb})
  endtask
  task automatic t_bit;
    bit_case(8'hAF, 8'hA8, space_sfr, 1'b0, 8'h72);
    bit_case(8'h00, 8'h20, space_ram, 1'b1, 8'h7B);
    bit_case(8'h7F, 8'h2F, space_ram, 1'b1, 8'hF5);
  endtask
  // reset in mid-run over a standing request, then a request after release
  task automatic t_reset;
    @(negedge clk);
    nrst = 1'b0;
    decode_valid = 1'b1;
    mode = mode_far;
    byte2 = 8'h12;
    byte3 = 8'h34;
    @(negedge clk);
    `CHK({op_valid, imm_valid, data_pointer_load, ext_read, ext_write, code_read, jump_valid, bit_valid, unsupported}, 9'h000)
    `CHK({op_space, jump_target, ext_addr}, {space_none, 16'h0000, 16'h0000})
    nrst = 1'b1;
    decode_valid = 1'b0;
    issue(mode_far, 8'h02, 8'h12, 8'h34);
    `CHK({jump_valid, jump_target}, {1'b1, 16'h1234})
  endtask
  task automatic stop_test;
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // clock at 20 MHz
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard
  initial
  begin
    #100000;
    err_total++;
    stop_test();
  end
  // reset then scenarios
  initial
  begin
    {nrst, decode_valid, bit_value, bank_sel, opcode, byte2, byte3} = '0;
    {accumulator, ram_addr, data_pointer, pc_next} = '0;
    mode = mode_none;
    err_total = 0;
    total_checks = 0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_operand();
    t_immediate();
    t_external();
    t_branch();
    t_bit();
    t_reset();
    stop_test();
  end
endmodule
